//--- qpc_regs.svh
// Constants for the quad potentiometer command decoder and its two-wire host
// Functional notes
// [R01] Stop after storage change starts write
// [R02] Busy write ignores serial inputs entirely
// [R03] No acknowledge to address while busy
// [R04] Acknowledge address once write has finished
// [R05] Instruction: opcode, pot select, slot select
// [R06] Transfers end after instruction acknowledge
// [R07] Slot to wiper is volatile, settles later
// [R08] Wiper to slot is timed storage write
// [R09] Transfers single channel or all four
// [R10] Register reads and writes take three bytes
// [R11] Data high clock pulse steps wiper up
// [R12] Data low clock pulse steps wiper down
// [R13] Opcodes nine, A, B, C read/write
// [R14] Opcodes D, E single channel transfers
// [R15] Opcodes one, eight global transfers
// [R16] Opcode two enables increment/decrement mode
// [R17] Unused select fields are ignored
// [R18] Six-bit wiper selects one of 64 taps
// [R19] Reset loads wiper from slot zero
// [R20] Four stored slots, write under ten ms
// [R21] Stepping saturates unless chain flag set
// [R22] Address matches type code and straps
// [R23] Acknowledge address, instruction, data byte
// [R24] Data byte: chain, wiper off, position
`ifndef QPC_REGS_SVH
`define QPC_REGS_SVH

// ****************************************************************
// Instruction field layout and opcodes
// ****************************************************************
`define QPC_OP_RD_WIPER 4'h9
`define QPC_OP_WR_WIPER 4'hA
`define QPC_OP_RD_SLOT 4'hB
`define QPC_OP_WR_SLOT 4'hC
`define QPC_OP_XFR_TO_WIPER 4'hD
`define QPC_OP_XFR_TO_SLOT 4'hE
`define QPC_OP_GXFR_TO_WIPER 4'h1
`define QPC_OP_GXFR_TO_SLOT 4'h8
`define QPC_OP_INCDEC 4'h2
`define QPC_OPC_MSB 7
`define QPC_OPC_LSB 4
`define QPC_POT_MSB 3
`define QPC_POT_LSB 2
`define QPC_SLOT_MSB 1
`define QPC_SLOT_LSB 0
`define QPC_CHAIN_BIT 7
`define QPC_WOFF_BIT 6
`define QPC_POS_MSB 5
`define QPC_POS_MAX 6'h3F

// ****************************************************************
// Reset values
// ****************************************************************
`define QPC_WIPER_RST 8'h00
`define QPC_SLOT_RST 8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define QPC_CLK_MHZ 20
`define QPC_NVW_TIME_US 5000
`define QPC_NVW_CYC (`QPC_NVW_TIME_US * `QPC_CLK_MHZ)
`define QPC_SETTLE_NS 500
`define QPC_SETTLE_CYC ((`QPC_SETTLE_NS * `QPC_CLK_MHZ + 999) / 1000)
`define QPC_SCL_PERIOD_NS 10000
`define QPC_QTR_CYC (`QPC_SCL_PERIOD_NS * `QPC_CLK_MHZ / 4000)

// ****************************************************************
// Host command port offsets and fields
// ****************************************************************
`define QPC_H_SLAVE 8'h00
`define QPC_H_INSTR 8'h04
`define QPC_H_DATA 8'h08
`define QPC_H_CTRL 8'h0C
`define QPC_H_STATUS 8'h10
`define QPC_H_RXDATA 8'h14
`define QPC_CTRL_NB_MSB 1
`define QPC_CTRL_NB_LSB 0
`define QPC_CTRL_READ 2
`define QPC_CTRL_INCDEC 3
`define QPC_STAT_BUSY 0
`define QPC_STAT_NACK 1
`define QPC_INC_DIR_BIT 7

`endif

//--- qpc_pkg.sv
// Types shared by both ends of the potentiometer link
package qpc_pkg;

  typedef enum logic [7:0] {
    QPC_D_PWRUP = 8'h01,
    QPC_D_IDLE = 8'h02,
    QPC_D_RX = 8'h04,
    QPC_D_ACK = 8'h08,
    QPC_D_TX = 8'h10,
    QPC_D_TXACK = 8'h20,
    QPC_D_INCDEC = 8'h40,
    QPC_D_BUSY = 8'h80
  } qpc_dev_state_t;

  typedef enum logic [4:0] {
    QPC_H_IDLE = 5'h01,
    QPC_H_START = 5'h02,
    QPC_H_BIT = 5'h04,
    QPC_H_PULSE = 5'h08,
    QPC_H_STOP = 5'h10
  } qpc_host_state_t;

  typedef struct packed {
    qpc_dev_state_t st;
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
    logic [3:0] strap1;
    logic [3:0] strap2;
    logic [3:0] strap;
    logic [3:0] cnt;
    logic [1:0] idx;
    logic [7:0] sh;
    logic [7:0] instr;
    logic oe_n;
    logic nv_pend;
    logic [23:0] busy_cnt;
    logic [7:0] settle;
    logic [3:0][7:0] wiper_position;
    logic [3:0][3:0][7:0] slot;
    logic [3:0][63:0] tap;
    logic [3:0] woff;
    logic [3:0] chain;
  } qpc_dev_t;

  typedef struct packed {
    qpc_host_state_t st;
    logic sda1;
    logic sda2;
    logic [1:0] q;
    logic [15:0] tick;
    logic [3:0] bitn;
    logic [1:0] bytn;
    logic [8:0] sh;
    logic [7:0] rx;
    logic scl;
    logic oe_n;
    logic nack;
    logic [7:0] slave;
    logic [7:0] instr;
    logic [7:0] data;
    logic [3:0] ctrl;
    logic [5:0] pulses;
    logic [7:0] rxdata;
    logic [7:0] rdata;
  } qpc_host_t;

endpackage

//--- qpc_link_if.sv
// Two-wire link between host and potentiometer decoder
`timescale 1ns/1ps
interface qpc_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;

  // Open-drain wire with pull-up: low while either end drives
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
endinterface

//--- qpc_device.sv
// Potentiometer end: serial slave, instruction decoder, wiper and slot storage
`timescale 1ns/1ps
`include "qpc_regs.svh"
module qpc_device #(
  parameter logic [3:0] DEV_TYPE = 4'h6, // Arbitrary type code
  parameter int NVW_CYC = `QPC_NVW_CYC,
  parameter int SETTLE_CYC = `QPC_SETTLE_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Link
  qpc_link_if.dev bus,
  // Straps
  input wire logic [3:0] i_strap_addr,
  // Potentiometer controls
  output logic [3:0][63:0] o_tap_sel,
  output logic [3:0] o_wiper_off,
  output logic [3:0] o_chain_en,
  output logic o_nv_busy
);

  qpc_pkg::qpc_dev_t r;
  qpc_pkg::qpc_dev_t n;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [3:0] opc;
  logic [1:0] pot;
  logic [1:0] sel;

  assign rise = r.scl2 & ~r.scl3;
  assign fall = ~r.scl2 & r.scl3;
  assign start = r.scl2 & r.scl3 & r.sda3 & ~r.sda2;
  assign stop = r.scl2 & r.scl3 & ~r.sda3 & r.sda2;
  assign opc = r.instr[`QPC_OPC_MSB:`QPC_OPC_LSB]; // [R05]
  assign pot = r.instr[`QPC_POT_MSB:`QPC_POT_LSB];
  assign sel = r.instr[`QPC_SLOT_MSB:`QPC_SLOT_LSB];

  function automatic logic legal(input logic [3:0] op);
    case (op)
      `QPC_OP_RD_WIPER, `QPC_OP_WR_WIPER, `QPC_OP_RD_SLOT, `QPC_OP_WR_SLOT,
      `QPC_OP_XFR_TO_WIPER, `QPC_OP_XFR_TO_SLOT, `QPC_OP_GXFR_TO_WIPER,
      `QPC_OP_GXFR_TO_SLOT, `QPC_OP_INCDEC: legal = 1'b1; // [R13]
      default: legal = 1'b0;
    endcase
  endfunction

  // One step toward either terminal
  function automatic logic [7:0] step(input logic [7:0] w, input logic up);
    logic [5:0] p;
    p = w[`QPC_POS_MSB:0];
    if (up) begin
      if (p != `QPC_POS_MAX || w[`QPC_CHAIN_BIT]) begin // [R21]
        p = p + 6'h01; // [R11]
      end
    end else begin
      if (p != 6'h00 || w[`QPC_CHAIN_BIT]) begin // [R21]
        p = p - 6'h01; // [R12]
      end
    end
    step = {w[7:6], p};
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n = r;
    n.scl1 = bus.scl;
    n.scl2 = r.scl1;
    n.scl3 = r.scl2;
    n.sda1 = bus.sda;
    n.sda2 = r.sda1;
    n.sda3 = r.sda2;
    n.strap1 = i_strap_addr;
    n.strap2 = r.strap1;
    case (r.st)
      qpc_pkg::QPC_D_PWRUP: begin
        n.cnt = r.cnt + 4'h1;
        if (r.cnt == 4'h3) begin
          n.strap = r.strap2;
          for (int c = 0; c < 4; c++) begin
            n.wiper_position[c] = r.slot[c][0]; // [R19]
          end
          n.cnt = 4'h0;
          n.st = qpc_pkg::QPC_D_IDLE;
        end
      end
      qpc_pkg::QPC_D_IDLE: begin
      end
      qpc_pkg::QPC_D_RX: begin
        if (rise) begin
          n.sh = {r.sh[6:0], r.sda2};
          n.cnt = r.cnt + 4'h1;
        end else if (fall && r.cnt == 4'h8) begin
          n.cnt = 4'h0;
          n.st = qpc_pkg::QPC_D_ACK;
          n.oe_n = 1'b0; // [R23]
          if (r.idx == 2'h0) begin
            if (r.sh[7:4] != DEV_TYPE || r.sh[3:0] != r.strap) begin // [R22]
              n.st = qpc_pkg::QPC_D_IDLE;
              n.oe_n = 1'b1;
            end
          end else if (r.idx == 2'h1) begin
            n.instr = r.sh;
            if (!legal(r.sh[`QPC_OPC_MSB:`QPC_OPC_LSB])) begin
              n.st = qpc_pkg::QPC_D_IDLE;
              n.oe_n = 1'b1;
            end
          end else begin
            if (opc == `QPC_OP_WR_WIPER) begin
              n.wiper_position[pot] = r.sh; // [R24]
            end else begin
              n.slot[pot][sel] = r.sh;
              n.nv_pend = 1'b1; // [R20]
            end
          end
        end
      end
      qpc_pkg::QPC_D_ACK: begin
        if (fall) begin
          n.oe_n = 1'b1;
          n.idx = r.idx + 2'h1;
          n.st = qpc_pkg::QPC_D_RX;
          if (r.idx == 2'h1) begin
            case (opc)
              `QPC_OP_RD_WIPER, `QPC_OP_RD_SLOT: begin // [R10]
                n.sh = (opc == `QPC_OP_RD_WIPER) ? r.wiper_position[pot] : r.slot[pot][sel]; // [R17]
                n.oe_n = n.sh[7];
                n.sh = {n.sh[6:0], 1'b0};
                n.cnt = 4'h1;
                n.st = qpc_pkg::QPC_D_TX;
              end
              `QPC_OP_XFR_TO_WIPER: begin
                n.wiper_position[pot] = r.slot[pot][sel]; // [R14] [R07]
                n.st = qpc_pkg::QPC_D_IDLE; // [R06]
              end
              `QPC_OP_XFR_TO_SLOT: begin
                n.slot[pot][sel] = r.wiper_position[pot]; // [R14]
                n.nv_pend = 1'b1; // [R08]
                n.st = qpc_pkg::QPC_D_IDLE;
              end
              `QPC_OP_GXFR_TO_WIPER: begin
                for (int c = 0; c < 4; c++) begin
                  n.wiper_position[c] = r.slot[c][sel]; // [R15] [R09]
                end
                n.st = qpc_pkg::QPC_D_IDLE;
              end
              `QPC_OP_GXFR_TO_SLOT: begin
                for (int c = 0; c < 4; c++) begin
                  n.slot[c][sel] = r.wiper_position[c]; // [R15] [R09]
                end
                n.nv_pend = 1'b1;
                n.st = qpc_pkg::QPC_D_IDLE;
              end
              `QPC_OP_INCDEC: begin
                n.st = qpc_pkg::QPC_D_INCDEC; // [R16]
              end
              default: begin
                n.st = qpc_pkg::QPC_D_RX;
              end
            endcase
          end else if (r.idx == 2'h2) begin
            n.st = qpc_pkg::QPC_D_IDLE;
          end
        end
      end
      qpc_pkg::QPC_D_TX: begin
        if (fall) begin
          if (r.cnt == 4'h8) begin
            n.oe_n = 1'b1;
            n.st = qpc_pkg::QPC_D_TXACK;
          end else begin
            n.oe_n = r.sh[7];
            n.sh = {r.sh[6:0], 1'b0};
            n.cnt = r.cnt + 4'h1;
          end
        end
      end
      qpc_pkg::QPC_D_TXACK: begin
        if (fall) begin
          n.st = qpc_pkg::QPC_D_IDLE;
        end
      end
      qpc_pkg::QPC_D_INCDEC: begin
        // Level caught while clock is high, step taken when the pulse ends
        if (rise) begin
          n.sh[0] = r.sda2;
        end else if (fall) begin
          n.wiper_position[pot] = step(r.wiper_position[pot], r.sh[0]); // [R11] [R12]
        end
      end
      qpc_pkg::QPC_D_BUSY: begin
        n.oe_n = 1'b1; // [R02] [R03]
        if (r.busy_cnt == 24'h000000) begin
          n.st = qpc_pkg::QPC_D_IDLE; // [R04]
        end else begin
          n.busy_cnt = r.busy_cnt - 24'h000001;
        end
      end
      default: begin
        n.st = qpc_pkg::QPC_D_IDLE;
      end
    endcase
    if (r.st != qpc_pkg::QPC_D_BUSY && r.st != qpc_pkg::QPC_D_PWRUP) begin // [R02]
      if (start) begin
        n.st = qpc_pkg::QPC_D_RX;
        n.idx = 2'h0;
        n.cnt = 4'h0;
        n.oe_n = 1'b1;
      end else if (stop) begin
        n.oe_n = 1'b1;
        n.st = qpc_pkg::QPC_D_IDLE;
        if (r.nv_pend) begin
          n.st = qpc_pkg::QPC_D_BUSY; // [R01]
          n.busy_cnt = 24'(NVW_CYC - 1); // [R08] [R20]
          n.nv_pend = 1'b0;
        end
      end
    end
    // Shown wiper follows the register after the settling delay
    if (n.wiper_position != r.wiper_position) begin
      n.settle = 8'(SETTLE_CYC); // [R07]
    end else if (r.settle != 8'h00) begin
      n.settle = r.settle - 8'h01;
    end else begin
      for (int c = 0; c < 4; c++) begin
        n.tap[c] = 64'h0000000000000001 << r.wiper_position[c][`QPC_POS_MSB:0]; // [R18]
        n.woff[c] = r.wiper_position[c][`QPC_WOFF_BIT]; // [R24]
        n.chain[c] = r.wiper_position[c][`QPC_CHAIN_BIT];
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r <= '0;
      r.st <= qpc_pkg::QPC_D_PWRUP;
      r.oe_n <= 1'b1;
      r.scl1 <= 1'b1;
      r.scl2 <= 1'b1;
      r.scl3 <= 1'b1;
      r.sda1 <= 1'b1;
      r.sda2 <= 1'b1;
      r.sda3 <= 1'b1;
      r.wiper_position <= {4{`QPC_WIPER_RST}};
      r.slot <= {16{`QPC_SLOT_RST}};
      r.tap <= {4{64'h0000000000000001}};
    end else begin
      r <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe_n = r.oe_n;
  assign o_nv_busy = (r.st == qpc_pkg::QPC_D_BUSY);

  for (genvar c = 0; c < 4; c++) begin : g_ch
    assign o_tap_sel[c] = r.tap[c];
    assign o_wiper_off[c] = r.woff[c];
    assign o_chain_en[c] = r.chain[c];
  end

endmodule

//--- qpc_host.sv
// Host end: command registers and two-wire master that drives the link clock
`timescale 1ns/1ps
`include "qpc_regs.svh"
module qpc_host #(
  parameter int QTR_CYC = `QPC_QTR_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Command port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_busy,
  // Link
  qpc_link_if.host bus
);

  qpc_pkg::qpc_host_t r;
  qpc_pkg::qpc_host_t n;
  logic adv;
  logic idle;
  logic rx_byte;

  assign adv = (r.tick == 16'(QTR_CYC - 1));
  assign idle = (r.st == qpc_pkg::QPC_H_IDLE);
  assign rx_byte = r.ctrl[`QPC_CTRL_READ] & (r.bytn == 2'h2);

  always_comb begin
    n = r;
    n.sda1 = bus.sda;
    n.sda2 = r.sda1;
    n.rdata = 8'h00;
    n.tick = (adv || idle) ? 16'h0000 : r.tick + 16'h0001;
    if (i_rd) begin
      case (i_addr)
        `QPC_H_SLAVE: n.rdata = r.slave;
        `QPC_H_INSTR: n.rdata = r.instr;
        `QPC_H_DATA: n.rdata = r.data;
        `QPC_H_CTRL: n.rdata = {4'h0, r.ctrl};
        `QPC_H_STATUS: n.rdata = {6'h00, r.nack, ~idle};
        `QPC_H_RXDATA: n.rdata = r.rxdata;
        default: n.rdata = 8'h00;
      endcase
    end
    if (i_wr && idle) begin
      case (i_addr)
        `QPC_H_SLAVE: n.slave = i_wdata;
        `QPC_H_INSTR: n.instr = i_wdata;
        `QPC_H_DATA: n.data = i_wdata;
        `QPC_H_CTRL: begin
          n.ctrl = i_wdata[3:0];
          n.st = qpc_pkg::QPC_H_START; // [R03]
          n.q = 2'h0;
          n.nack = 1'b0;
          n.bytn = 2'h0;
          n.bitn = 4'h0;
        end
        default: begin
        end
      endcase
    end
    if (adv) begin
      case (r.st)
        qpc_pkg::QPC_H_START: begin
          n.q = r.q + 2'h1;
          if (r.q == 2'h0) begin
            n.oe_n = 1'b0;
          end else begin
            n.scl = 1'b0;
            n.sh = {r.slave, 1'b1};
            n.q = 2'h0;
            n.st = qpc_pkg::QPC_H_BIT;
          end
        end
        qpc_pkg::QPC_H_BIT, qpc_pkg::QPC_H_PULSE: begin
          n.q = r.q + 2'h1;
          case (r.q)
            2'h0: n.oe_n = (r.st == qpc_pkg::QPC_H_BIT) ? r.sh[8] : r.data[`QPC_INC_DIR_BIT]; // [R11] [R12]
            2'h1: n.scl = 1'b1;
            2'h2: n.rx = {r.rx[6:0], r.sda2};
            default: begin
              n.scl = 1'b0;
              n.sh = {r.sh[7:0], 1'b1};
              n.bitn = r.bitn + 4'h1;
              // Read byte is whole after its eighth sample; the ninth is the master's nack
              if (rx_byte && r.bitn == 4'h7) begin
                n.rxdata = r.rx;
              end
              if (r.st == qpc_pkg::QPC_H_PULSE) begin
                n.pulses = r.pulses - 6'h01;
                if (r.pulses == 6'h01) begin
                  n.st = qpc_pkg::QPC_H_STOP;
                end
              end else if (r.bitn == 4'h8) begin
                n.bitn = 4'h0;
                n.bytn = r.bytn + 2'h1;
                if (rx_byte) begin
                  n.st = qpc_pkg::QPC_H_STOP;
                end else if (r.rx[0]) begin
                  n.nack = 1'b1; // [R03]
                  n.st = qpc_pkg::QPC_H_STOP;
                end else if (r.bytn + 2'h1 == r.ctrl[`QPC_CTRL_NB_MSB:`QPC_CTRL_NB_LSB]) begin
                  n.st = qpc_pkg::QPC_H_STOP; // [R04] [R06]
                  if (r.ctrl[`QPC_CTRL_INCDEC] && r.data[5:0] != 6'h00) begin
                    n.pulses = r.data[5:0];
                    n.st = qpc_pkg::QPC_H_PULSE;
                  end
                end else begin
                  n.sh = (r.bytn == 2'h0) ? {r.instr, 1'b1} : {r.data, 1'b1};
                  if (r.bytn == 2'h1 && r.ctrl[`QPC_CTRL_READ]) begin
                    n.sh = 9'h1FF; // [R10]
                  end
                end
              end
            end
          endcase
        end
        qpc_pkg::QPC_H_STOP: begin
          n.q = r.q + 2'h1;
          case (r.q)
            2'h0: n.oe_n = 1'b0;
            2'h1: n.scl = 1'b1;
            default: begin
              n.oe_n = 1'b1;
              n.q = 2'h0;
              n.st = qpc_pkg::QPC_H_IDLE;
            end
          endcase
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r <= '0;
      r.st <= qpc_pkg::QPC_H_IDLE;
      r.scl <= 1'b1;
      r.oe_n <= 1'b1;
      r.sda1 <= 1'b1;
      r.sda2 <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign bus.scl = r.scl;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe_n = r.oe_n;
  assign o_rdata = r.rdata;
  assign o_busy = ~idle;

endmodule

//--- qpc_link_properties.sv
// Assertions on the two-wire link between host and potentiometer device
`timescale 1ns/1ps
module qpc_link_properties #(
  parameter int NVW_CYC = 2000
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n,
  // Device outputs
  input wire logic o_nv_busy,
  input wire logic [3:0][63:0] o_tap_sel
);
  logic [15:0] busy_len;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  // Length of the current storage write
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_len <= 16'h0000;
    end else if (o_nv_busy) begin
      busy_len <= busy_len + 16'h0001;
    end else begin
      busy_len <= 16'h0000;
    end
  end

  busy_start_a: assert property ($rose(o_nv_busy) |-> scl && sda)
    else $error("Storage write began outside a stop");
  busy_noack_a: assert property (o_nv_busy |-> dev_sda_oe_n)
    else $error("Device drove the data line during a storage write");
  busy_len_a: assert property ($fell(o_nv_busy) |-> busy_len >= NVW_CYC - 1 && busy_len <= NVW_CYC + 1)
    else $error("Storage write length off");
  busy_max_a: assert property (busy_len <= NVW_CYC + 1)
    else $error("Storage write ran too long");
  ack_drive_a: assert property ($fell(dev_sda_oe_n) |-> !scl)
    else $error("Device took the data line while the clock was high");
  ack_release_a: assert property ($rose(dev_sda_oe_n) |-> !scl)
    else $error("Device let go of the data line while the clock was high");
  // Both ends may pull low together while the clock is low; never while it is high
  one_driver_a: assert property (!dev_sda_oe_n && scl |-> host_sda_oe_n)
    else $error("Both ends drive the data line");
  scl_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("Clock high pulse too short");
  tap_onehot_a: assert property ($onehot(o_tap_sel[0]) && $onehot(o_tap_sel[1])
    && $onehot(o_tap_sel[2]) && $onehot(o_tap_sel[3]))
    else $error("Tap select not one-hot");
endmodule

//--- quad_pot_command_decoder_tb.sv
// Self-checking bench for the potentiometer host and device pair
`timescale 1ns/1ps
module quad_pot_command_decoder_tb;
  localparam int NVW = 2000;
  logic i_clk;
  logic i_sys_rst;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [7:0] o_rdata;
  logic o_busy;
  logic [3:0][63:0] o_tap_sel;
  logic [3:0] o_wiper_off;
  logic [3:0] o_chain_en;
  logic o_nv_busy;
  logic [7:0] got;
  int bad_count;
  int checks;
  int cycles;

  qpc_link_if link();
  qpc_device #(.DEV_TYPE(4'h6), .NVW_CYC(NVW), .SETTLE_CYC(10)) qpc_device_i (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .bus(link.dev), .i_strap_addr(4'h3), .o_tap_sel(o_tap_sel),
    .o_wiper_off(o_wiper_off), .o_chain_en(o_chain_en), .o_nv_busy(o_nv_busy));
  qpc_host #(.QTR_CYC(8)) qpc_host_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_busy(o_busy), .bus(link.host));
  qpc_link_properties #(.NVW_CYC(NVW)) qpc_link_properties_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .scl(link.scl), .sda(link.sda), .host_sda_oe_n(link.host_sda_oe_n),
    .dev_sda_oe_n(link.dev_sda_oe_n), .o_nv_busy(o_nv_busy), .o_tap_sel(o_tap_sel));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic print_verdict();
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] v, input logic [63:0] e);
    checks++;
    if (v !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, v, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    got = o_rdata;
  endtask

  // One host transaction, then status must show idle and the expected acknowledge
  task automatic cmd(input logic [7:0] sl, input logic [7:0] ins, input logic [7:0] d,
                     input logic [7:0] ctl, input logic nack);
    int n;
    wr(8'h00, sl);
    wr(8'h04, ins);
    wr(8'h08, d);
    wr(8'h0C, ctl);
    repeat (2) @(negedge i_clk);
    for (n = 0; n < 4000 && o_busy === 1'b1; n++) @(negedge i_clk);
    // Let the device see the stop through its synchroniser
    repeat (4) @(negedge i_clk);
    rd(8'h10);
    chk(got[1:0], {nack, 1'b0});
  endtask

  task automatic settle();
    repeat (20) @(negedge i_clk);
  endtask

  task automatic wait_nv();
    int n;
    for (n = 0; n < NVW + 100 && o_nv_busy === 1'b1; n++) @(negedge i_clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_power();
    repeat (30) @(negedge i_clk);
    for (int k = 0; k < 4; k++) chk(o_tap_sel[k], 64'h1);
    chk({o_wiper_off, o_chain_en}, 8'h00);
    rd(8'h20);
    chk(got, 8'h00);
  endtask

  task automatic t_addr();
    cmd(8'h64, 8'h90, 8'h00, 8'h01, 1'b1);
    cmd(8'h53, 8'h90, 8'h00, 8'h01, 1'b1);
    cmd(8'h63, 8'h90, 8'h00, 8'h01, 1'b0);
  endtask

  task automatic t_wiper();
    cmd(8'h63, 8'hAB, 8'hC5, 8'h03, 1'b0);
    settle();
    chk(o_tap_sel[2], 64'h1 << 5);
    chk({o_chain_en[2], o_wiper_off[2]}, 2'b11);
    cmd(8'h63, 8'h9B, 8'h00, 8'h07, 1'b0);
    rd(8'h14);
    chk(got, 8'hC5);
  endtask

  task automatic t_slot();
    cmd(8'h63, 8'hC6, 8'h2A, 8'h03, 1'b0);
    chk(o_nv_busy, 1'b1);
    cmd(8'h63, 8'hA4, 8'h11, 8'h03, 1'b1);
    cmd(8'h63, 8'h00, 8'h00, 8'h01, 1'b1);
    wait_nv();
    cmd(8'h63, 8'h00, 8'h00, 8'h01, 1'b0);
    chk(o_tap_sel[1], 64'h1);
    cmd(8'h63, 8'hB6, 8'h00, 8'h07, 1'b0);
    rd(8'h14);
    chk(got, 8'h2A);
  endtask

  task automatic t_xfr();
    cmd(8'h63, 8'hD6, 8'h00, 8'h02, 1'b0);
    settle();
    chk(o_nv_busy, 1'b0);
    chk(o_tap_sel[1], 64'h1 << 42);
    cmd(8'h63, 8'hE9, 8'h00, 8'h02, 1'b0);
    chk(o_nv_busy, 1'b1);
    wait_nv();
    cmd(8'h63, 8'hB9, 8'h00, 8'h07, 1'b0);
    rd(8'h14);
    chk(got, 8'hC5);
  endtask

  task automatic t_global();
    logic [3:0][63:0] exp;
    exp = {64'h1, 64'h1 << 5, 64'h1 << 42, 64'h1};
    cmd(8'h63, 8'h83, 8'h00, 8'h02, 1'b0);
    chk(o_nv_busy, 1'b1);
    wait_nv();
    cmd(8'h63, 8'hA0, 8'h10, 8'h03, 1'b0);
    cmd(8'h63, 8'h1F, 8'h00, 8'h02, 1'b0);
    settle();
    for (int k = 0; k < 4; k++) chk(o_tap_sel[k], exp[k]);
  endtask

  task automatic t_incdec();
    cmd(8'h63, 8'h24, 8'h83, 8'h0A, 1'b0);
    settle();
    chk(o_tap_sel[1], 64'h1 << 45);
    cmd(8'h63, 8'h27, 8'h05, 8'h0A, 1'b0);
    settle();
    chk(o_tap_sel[1], 64'h1 << 40);
    cmd(8'h63, 8'h20, 8'h02, 8'h0A, 1'b0);
    settle();
    chk(o_tap_sel[0], 64'h1);
  endtask

  // ****************************************
  // Clock, timeout and main sequence
  // ****************************************
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    i_sys_rst = 1'b1;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_power();
    t_addr();
    t_wiper();
    t_slot();
    t_xfr();
    t_global();
    t_incdec();
    print_verdict();
  end
endmodule
